//--- inc/bers_pkg.sv
// Types shared by the brake engage sequencer files
// Assumes nothing beyond the constants header
`default_nettype none

package bers_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_REL, ST_RUN, ST_DLY, ST_PH, ST_WAIT
  } bers_state_t;

  typedef enum logic [1:0] {
    JM_DEFAULT, JM_AUTO, JM_MANUAL, JM_RSVD
  } bers_jmode_t;

  typedef struct packed {
    bers_jmode_t jump_mode;
    logic [1:0]  ms_comm_mode;
    logic        closed_loop_sync_mode;
    logic        closed_loop_vector_mode;
    logic        hoisting;
    logic        restart_policy;
    logic        rev_engage;
  } bers_ctrl_t;

  typedef struct packed {
    logic        rev_active;
    logic        eff_policy;
    logic        brake_engaged;
    bers_state_t state;
  } bers_stat_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } bers_bus_t;

endpackage : bers_pkg

`default_nettype wire

//--- inc/bers_regs.svh
// Register offsets, reset values, limits and tick timing of the sequencer
// Assumes a 100 MHz system clock; all times count in 10 ms ticks
`ifndef BERS_REGS_SVH
`define BERS_REGS_SVH

`define BERS_AW          5
`define BERS_TW          11
`define BERS_LW          7
`define BERS_CTRL_W      9
`define BERS_HI_LSB      16

`define BERS_A_CTRL      5'h00
`define BERS_A_DLY       5'h04
`define BERS_A_ENG       5'h08
`define BERS_A_RSTW      5'h0C
`define BERS_A_REL       5'h10
`define BERS_A_FBF       5'h14
`define BERS_A_JDC       5'h18
`define BERS_A_STAT      5'h1C

`define BERS_RST_CTRL    9'h000
`define BERS_RST_DLY     11'h000
`define BERS_RST_ENG     11'h032
`define BERS_RST_RSTW    11'h000
`define BERS_RST_REL     11'h032
`define BERS_RST_FBF     11'h000
`define BERS_RST_JUMP    7'h00
`define BERS_RST_DC      7'h46

`define BERS_MAX_DLY     11'h1F4
`define BERS_MAX_ENG     11'h1F4
`define BERS_MAX_RSTW    11'h5DC
`define BERS_MAX_REL     11'h1F4
`define BERS_MAX_JUMP    7'h64
`define BERS_MAX_DC      7'h6E

`define BERS_CLK_MHZ     100
`define BERS_TICK_MS     10
`define BERS_TICK_CYC    (`BERS_TICK_MS * 1000 * `BERS_CLK_MHZ)

`endif

//--- rtl/bers_sequencer.sv
// Brake engage and restart sequencer with its control registers
// Assumes run, stop and reversal inputs come from logic on mclk_i
`include "bers_regs.svh"
`default_nettype none

// What this block does
// - Wait programmable engage delay, 0.01 s steps, up to 5 s, default 0.
// - Time engage phase, 0.01 s steps, up to 5 s, default 0.50 s.
// - Engage phase never shorter than the larger feedback filter time.
// - Reversal-engage setting engages brake at zero speed on reversal; default off.
// - Reversal frequency jump only open-loop hoisting, 0-10 Hz, off with reversal-engage.
// - Automatic jump uses rated slip; default auto only for open-loop hoisting.
// - Hold off new release for restart time, up to 15 s, default 0.
// - DC injection level one only traveling open-loop; max 1.1, default 0.7.
// - Master/slave mode other than off forces restart policy to full sequence.
// - Run during restart wait restarts the restart wait count from zero.
// - Run while reversal-engage active reinitialises the complete brake sequence.
// - Policy zero: run during engagement lets engage then release complete.
// - Policy one: run before engage delay ends acts at once, no engage.
// - Policy one: run during engage phase restarts after the release time.
// - Policy one: run after engage phase lets the sequence complete first.
module bers_sequencer #(
  parameter int unsigned TICK_CYC = `BERS_TICK_CYC
) (
  input  wire logic                   mclk_i,          // System clock, 100 MHz
  input  wire logic                   rstn_i,          // Sync reset, active low
  input  wire logic                   ce_i,            // Clock enable, freezes all
  input  wire bers_pkg::bers_bus_t    bus_i,           // Register port request
  output logic [31:0]                 rdata_o,         // Read data, cycle after read
  input  wire logic                   run_cmd_i,       // Run command level
  input  wire logic                   stop_reached_i,  // Engage condition reached
  input  wire logic                   rev_zero_i,      // Zero crossing on reversal
  input  wire logic [`BERS_LW-1:0]    rated_slip_i,    // Rated slip, 0.1 Hz units
  output logic                        brake_engage_o,  // Brake engage request
  output logic                        run_enable_o,    // Drive may run
  output logic                        jump_active_o,   // Reversal jump applied
  output logic [`BERS_LW-1:0]         jump_freq_o,     // Jump value, 0.1 Hz units
  output logic                        dc_inj_en_o,     // DC injection allowed
  output logic [`BERS_LW-1:0]         dc_inj_level_o   // Level, 0.01 rated current
);

  bers_pkg::bers_ctrl_t   ctrl_q;
  bers_pkg::bers_state_t  st_q;
  bers_pkg::bers_state_t  st_d;
  bers_pkg::bers_stat_t   stat;
  logic [`BERS_TW-1:0]    dly_q;
  logic [`BERS_TW-1:0]    eng_q;
  logic [`BERS_TW-1:0]    rstw_q;
  logic [`BERS_TW-1:0]    rel_q;
  logic [`BERS_TW-1:0]    fbf_a_q;
  logic [`BERS_TW-1:0]    fbf_b_q;
  logic [`BERS_LW-1:0]    jump_q;
  logic [`BERS_LW-1:0]    dc_q;
  logic [`BERS_TW-1:0]    cnt_q;
  logic [`BERS_TW-1:0]    lim;
  logic [`BERS_TW-1:0]    eng_lim;
  logic                   tick;
  logic                   run_q;
  logic                   run_rise;
  logic                   closed;
  logic                   eff_pol;
  logic                   full_seq;
  logic                   done;
  logic                   rev_act_q;
  logic                   jump_auto;

  function automatic logic [`BERS_TW-1:0] clamp_t(input logic [31:0]         v,
                                                  input logic [`BERS_TW-1:0] mx);
    return (v > 32'(mx)) ? mx : v[`BERS_TW-1:0];
  endfunction : clamp_t

  function automatic logic [`BERS_LW-1:0] clamp_l(input logic [31:0]         v,
                                                  input logic [`BERS_LW-1:0] mx);
    return (v > 32'(mx)) ? mx : v[`BERS_LW-1:0];
  endfunction : clamp_l

  bers_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .tick_o (tick)
  );

  // Register writes, out-of-range values saturate
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_q  <= bers_pkg::bers_ctrl_t'(`BERS_RST_CTRL);
      dly_q   <= `BERS_RST_DLY;
      eng_q   <= `BERS_RST_ENG;
      rstw_q  <= `BERS_RST_RSTW;
      rel_q   <= `BERS_RST_REL;
      fbf_a_q <= `BERS_RST_FBF;
      fbf_b_q <= `BERS_RST_FBF;
      jump_q  <= `BERS_RST_JUMP;
      dc_q    <= `BERS_RST_DC;
    end else if (ce_i && bus_i.we) begin
      unique case (bus_i.addr)
        `BERS_A_CTRL: ctrl_q  <= bers_pkg::bers_ctrl_t'(bus_i.wdata[`BERS_CTRL_W-1:0]);
        `BERS_A_DLY:  dly_q   <= clamp_t(bus_i.wdata, `BERS_MAX_DLY);
        `BERS_A_ENG:  eng_q   <= clamp_t(bus_i.wdata, `BERS_MAX_ENG);
        `BERS_A_RSTW: rstw_q  <= clamp_t(bus_i.wdata, `BERS_MAX_RSTW);
        `BERS_A_REL:  rel_q   <= clamp_t(bus_i.wdata, `BERS_MAX_REL);
        `BERS_A_FBF: begin
          fbf_a_q <= clamp_t({21'h00_0000, bus_i.wdata[`BERS_TW-1:0]}, `BERS_MAX_ENG);
          fbf_b_q <= clamp_t(32'(bus_i.wdata[`BERS_HI_LSB +: `BERS_TW]), `BERS_MAX_ENG);
        end
        `BERS_A_JDC: begin
          jump_q <= clamp_l({25'h000_0000, bus_i.wdata[`BERS_LW-1:0]}, `BERS_MAX_JUMP);
          dc_q   <= clamp_l(32'(bus_i.wdata[`BERS_HI_LSB +: `BERS_LW]), `BERS_MAX_DC);
        end
        default: ;
      endcase
    end
  end

  assign stat = '{rev_active:    rev_act_q,
                  eff_policy:    eff_pol,
                  brake_engaged: brake_engage_o,
                  state:         st_q};

  // Read data lives for exactly one cycle
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= 32'h0000_0000;
      if (bus_i.re) begin
        unique case (bus_i.addr)
          `BERS_A_CTRL: rdata_o <= 32'(ctrl_q);
          `BERS_A_DLY:  rdata_o <= 32'(dly_q);
          `BERS_A_ENG:  rdata_o <= 32'(eng_q);
          `BERS_A_RSTW: rdata_o <= 32'(rstw_q);
          `BERS_A_REL:  rdata_o <= 32'(rel_q);
          `BERS_A_FBF:  rdata_o <= (32'(fbf_b_q) << `BERS_HI_LSB) | 32'(fbf_a_q);
          `BERS_A_JDC:  rdata_o <= (32'(dc_q) << `BERS_HI_LSB) | 32'(jump_q);
          `BERS_A_STAT: rdata_o <= 32'(stat);
          default:      rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign closed   = ctrl_q.closed_loop_vector_mode | ctrl_q.closed_loop_sync_mode;
  assign eff_pol  = (ctrl_q.ms_comm_mode == 2'h0) & ctrl_q.restart_policy;
  assign full_seq = ~eff_pol | rev_act_q;
  assign run_rise = run_cmd_i & ~run_q;

  // Engage phase floor at the slower feedback filter
  always_comb begin
    eng_lim = eng_q;
    if (fbf_a_q > eng_lim) eng_lim = fbf_a_q;
    if (fbf_b_q > eng_lim) eng_lim = fbf_b_q;
  end

  always_comb begin
    unique case (st_q)
      bers_pkg::ST_REL:  lim = rel_q;
      bers_pkg::ST_DLY:  lim = dly_q;
      bers_pkg::ST_PH:   lim = eng_lim;
      bers_pkg::ST_WAIT: lim = rstw_q;
      default:           lim = '0;
    endcase
  end

  assign done = (cnt_q >= lim);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      bers_pkg::ST_IDLE: begin
        if (run_cmd_i) st_d = bers_pkg::ST_REL;
      end
      bers_pkg::ST_REL: begin
        if (done) st_d = bers_pkg::ST_RUN;
      end
      bers_pkg::ST_RUN: begin
        if (stop_reached_i || (rev_zero_i && ctrl_q.rev_engage)) begin
          st_d = bers_pkg::ST_DLY;
        end
      end
      bers_pkg::ST_DLY: begin
        if (run_rise && !full_seq) begin
          st_d = bers_pkg::ST_RUN;
        end else if (done) begin
          st_d = bers_pkg::ST_PH;
        end
      end
      bers_pkg::ST_PH: begin
        if (run_rise && !full_seq) begin
          st_d = bers_pkg::ST_REL;
        end else if (done) begin
          st_d = bers_pkg::ST_WAIT;
        end
      end
      bers_pkg::ST_WAIT: begin
        if (done && !run_rise) st_d = bers_pkg::ST_IDLE;
      end
      default: st_d = bers_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_q  <= bers_pkg::ST_IDLE;
      run_q <= 1'b0;
    end else if (ce_i) begin
      st_q  <= st_d;
      run_q <= run_cmd_i;
    end
  end

  // Phase timer restarts on every state change and on a run during the wait
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (st_d != st_q || (st_q == bers_pkg::ST_WAIT && run_rise)) begin
        cnt_q <= '0;
      end else if (tick && !(&cnt_q)) begin
        cnt_q <= cnt_q + `BERS_TW'(1);
      end
    end
  end

  // Remembers that the current engagement came from a reversal
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rev_act_q <= 1'b0;
    end else if (ce_i) begin
      if (st_q == bers_pkg::ST_RUN && st_d == bers_pkg::ST_DLY) begin
        rev_act_q <= ~stop_reached_i;
      end else if (st_d == bers_pkg::ST_IDLE || st_d == bers_pkg::ST_RUN) begin
        rev_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      brake_engage_o <= 1'b1;
      run_enable_o   <= 1'b0;
    end else if (ce_i) begin
      brake_engage_o <= (st_d == bers_pkg::ST_IDLE) || (st_d == bers_pkg::ST_PH) ||
                        (st_d == bers_pkg::ST_WAIT);
      run_enable_o   <= (st_d == bers_pkg::ST_RUN);
    end
  end

  // Factory default picks auto only for open-loop hoisting
  assign jump_auto = (ctrl_q.jump_mode == bers_pkg::JM_AUTO) ||
                     (ctrl_q.jump_mode != bers_pkg::JM_MANUAL && ctrl_q.hoisting && !closed);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      jump_active_o <= 1'b0;
      jump_freq_o   <= '0;
    end else if (ce_i) begin
      jump_active_o <= ctrl_q.hoisting && !closed && !ctrl_q.rev_engage &&
                       rev_zero_i && st_q == bers_pkg::ST_RUN;
      jump_freq_o   <= jump_auto ? ((rated_slip_i > `BERS_MAX_JUMP) ? `BERS_MAX_JUMP
                                    : rated_slip_i) : jump_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dc_inj_en_o    <= 1'b0;
      dc_inj_level_o <= '0;
    end else if (ce_i) begin
      dc_inj_en_o    <= !ctrl_q.hoisting && !closed &&
                        st_d == bers_pkg::ST_DLY;
      dc_inj_level_o <= dc_q;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_dly_exit;
    (ce_i && st_q == bers_pkg::ST_DLY && st_d == bers_pkg::ST_PH) |-> cnt_q >= dly_q;
  endproperty
  a_dly_exit: assert property (p_dly_exit) else $error("engage delay cut short");

  property p_ph_exit;
    (ce_i && st_q == bers_pkg::ST_PH && st_d == bers_pkg::ST_WAIT)
      |-> cnt_q >= eng_q && cnt_q >= fbf_a_q && cnt_q >= fbf_b_q;
  endproperty
  a_ph_exit: assert property (p_ph_exit) else $error("engage phase cut short");

  property p_rev;
    (ce_i && st_q == bers_pkg::ST_RUN && !stop_reached_i && !ctrl_q.rev_engage)
      |=> st_q == bers_pkg::ST_RUN;
  endproperty
  a_rev: assert property (p_rev) else $error("engaged on reversal while off");

  property p_jump;
    jump_active_o |-> $past(ctrl_q.hoisting && !closed && !ctrl_q.rev_engage);
  endproperty
  a_jump: assert property (p_jump) else $error("jump outside open-loop hoisting");

  property p_wait_exit;
    (ce_i && st_q == bers_pkg::ST_WAIT && st_d == bers_pkg::ST_IDLE) |-> cnt_q >= rstw_q;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("restart wait cut short");

  property p_dc;
    dc_inj_en_o |-> !$past(ctrl_q.hoisting) && !$past(closed);
  endproperty
  a_dc: assert property (p_dc) else $error("dc injection in wrong mode");

  property p_ms;
    (ce_i && ctrl_q.ms_comm_mode != 2'h0 && run_rise &&
     (st_q == bers_pkg::ST_DLY || st_q == bers_pkg::ST_PH))
      |=> st_q != bers_pkg::ST_RUN && st_q != bers_pkg::ST_REL;
  endproperty
  a_ms: assert property (p_ms) else $error("policy not forced in master/slave");

  property p_wait_run;
    (ce_i && st_q == bers_pkg::ST_WAIT && run_rise) |=> st_q == bers_pkg::ST_WAIT && cnt_q == '0;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("run in wait not restarted");

  property p_full;
    (ce_i && full_seq && st_q == bers_pkg::ST_DLY && run_rise) |=> st_q != bers_pkg::ST_RUN;
  endproperty
  a_full: assert property (p_full) else $error("full sequence interrupted");

  property p_pol1_dly;
    (ce_i && !full_seq && st_q == bers_pkg::ST_DLY && run_rise)
      |=> st_q == bers_pkg::ST_RUN ##0 !brake_engage_o;
  endproperty
  a_pol1_dly: assert property (p_pol1_dly) else $error("early run not taken");

  property p_pol1_ph;
    (ce_i && !full_seq && st_q == bers_pkg::ST_PH && run_rise) |=> st_q == bers_pkg::ST_REL;
  endproperty
  a_pol1_ph: assert property (p_pol1_ph) else $error("run in phase lacks release");

  property p_reset;
    !rstn_i |=> st_q == bers_pkg::ST_IDLE && brake_engage_o;
  endproperty
  a_reset: assert property (disable iff (1'b0) p_reset) else $error("bad reset state");

  c_full_cycle: cover property (st_q == bers_pkg::ST_WAIT ##1 st_q == bers_pkg::ST_IDLE);
  c_early_run:  cover property (st_q == bers_pkg::ST_DLY ##1 st_q == bers_pkg::ST_RUN);
  c_ph_run:     cover property (st_q == bers_pkg::ST_PH ##1 st_q == bers_pkg::ST_REL);
  c_rev:        cover property (rev_act_q && st_q == bers_pkg::ST_PH);

endmodule : bers_sequencer

`default_nettype wire

//--- rtl/bers_tick.sv
// Free running divider giving one-cycle timebase ticks
// Assumes the system clock domain and a synchronous active-low reset
`include "bers_regs.svh"
`default_nettype none

module bers_tick #(
  parameter int unsigned DIV = `BERS_TICK_CYC
) (
  input  wire logic mclk_i,  // System clock
  input  wire logic rstn_i,  // Sync reset, active low
  input  wire logic ce_i,    // Clock enable
  output logic      tick_o   // One-cycle tick
);

  localparam int unsigned W = $clog2(DIV + 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= (cnt_q == W'(DIV - 1));
      cnt_q  <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + W'(1);
    end
  end

endmodule : bers_tick

`default_nettype wire

//--- verification/bers_drive_model.sv
// Drive-side model: run command source, standstill detector, reversal zero crossing
// Assumes bench requests change just after a rising edge of mclk_i
`default_nettype none

module bers_drive_model (
  input  wire logic mclk_i,         // System clock
  input  wire logic rstn_i,         // Sync reset, active low
  input  wire logic run_req_i,      // Operator asks to run
  input  wire logic stop_req_i,     // Operator asks to stop
  input  wire logic rev_req_i,      // Operator reverses direction
  input  wire logic run_enable_i,   // Drive is running
  output logic      run_cmd_o,      // Run command level
  output logic      stop_reached_o, // Standstill reached
  output logic      rev_zero_o      // Zero crossing on reversal
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      run_cmd_o      <= 1'b0;
      stop_reached_o <= 1'b0;
      rev_zero_o     <= 1'b0;
    end else begin
      run_cmd_o      <= run_req_i;
      stop_reached_o <= stop_req_i;
      // Speed only crosses zero while the motor turns
      rev_zero_o     <= rev_req_i & run_enable_i;
    end
  end
endmodule : bers_drive_model

`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the brake engage sequencer
// Assumes the package, design files and drive-side model are compiled first
`include "bers_regs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TICK = 4;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } bers_row_t;

  typedef struct packed {
    logic [8:0] ctrl;
    logic       act;
    logic [6:0] freq;
  } bers_jrow_t;

  logic                mclk_i;
  logic                rstn_i     = 1'b0;
  logic                run_req    = 1'b0;
  logic                stop_req   = 1'b0;
  logic                rev_req    = 1'b0;
  logic                run_cmd;
  logic                stop_r;
  logic                rev_z;
  logic                brake;
  logic                run_en;
  logic                jmp_act;
  logic                dc_en;
  logic [6:0]          jmp_f;
  logic [6:0]          dc_lvl;
  logic [31:0]         rdata;
  logic [31:0]         d;
  bers_pkg::bers_bus_t bus        = '0;
  int                  num_errors = 0;
  int                  compares   = 0;
  int                  n;

  bers_row_t rows [16] = '{
    '{1'b0, `BERS_A_CTRL, 32'h0, 32'h0},
    '{1'b0, `BERS_A_DLY, 32'h0, 32'h0},
    '{1'b0, `BERS_A_ENG, 32'h0, 32'h32},
    '{1'b0, `BERS_A_RSTW, 32'h0, 32'h0},
    '{1'b0, `BERS_A_REL, 32'h0, 32'h32},
    '{1'b0, `BERS_A_FBF, 32'h0, 32'h0},
    '{1'b0, `BERS_A_JDC, 32'h0, 32'h0046_0000},
    '{1'b0, `BERS_A_STAT, 32'h0, 32'h8},
    '{1'b1, `BERS_A_DLY, 32'h7FF, 32'h1F4},
    '{1'b1, `BERS_A_ENG, 32'hFFFF, 32'h1F4},
    '{1'b1, `BERS_A_RSTW, 32'hFFFF, 32'h5DC},
    '{1'b1, `BERS_A_REL, 32'hFFFF, 32'h1F4},
    '{1'b1, `BERS_A_FBF, 32'hFFFF_FFFF, 32'h01F4_01F4},
    '{1'b1, `BERS_A_JDC, 32'hFFFF_FFFF, 32'h006E_0064},
    '{1'b1, `BERS_A_STAT, 32'hFF, 32'h8},
    '{1'b1, 5'h02, 32'hFFFF_FFFF, 32'h0}
  };

  // Hoisting open loop gives a jump; closed loop or traveling gives none
  bers_jrow_t jrows [5] = '{
    '{9'h104, 1'b1, 7'h19},
    '{9'h084, 1'b1, 7'h11},
    '{9'h004, 1'b1, 7'h11},
    '{9'h10C, 1'b0, 7'h00},
    '{9'h100, 1'b0, 7'h00}
  };

  bers_sequencer #(.TICK_CYC(TICK)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .bus_i(bus), .rdata_o(rdata),
    .run_cmd_i(run_cmd), .stop_reached_i(stop_r), .rev_zero_i(rev_z),
    .rated_slip_i(7'h11), .brake_engage_o(brake), .run_enable_o(run_en),
    .jump_active_o(jmp_act), .jump_freq_o(jmp_f), .dc_inj_en_o(dc_en),
    .dc_inj_level_o(dc_lvl)
  );

  bers_drive_model drv (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .run_req_i(run_req), .stop_req_i(stop_req),
    .rev_req_i(rev_req), .run_enable_i(run_en), .run_cmd_o(run_cmd),
    .stop_reached_o(stop_r), .rev_zero_o(rev_z)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [4:0] a, input logic [31:0] w);
    bus <= '{addr: a, wdata: w, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    bus <= '0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    @(posedge mclk_i);
    r = rdata;
  endtask : rd

  // Polls the state field; cnt gives cycles spent polling
  task automatic wait_st(input logic [2:0] st, output int cnt);
    logic [31:0] s;
    cnt = 0;
    s   = {29'h0, ~st};
    while (s[2:0] !== st && cnt < 600) begin
      rd(`BERS_A_STAT, s);
      cnt += 2;
    end
    chk("state", 32'(st), 32'(s[2:0]));
  endtask : wait_st

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    chk("brake_rst", 32'h1, 32'(brake));
    chk("run_en_rst", 32'h0, 32'(run_en));
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk($sformatf("reg%h", rows[i].addr), rows[i].exp, d);
    end
    wr(`BERS_A_DLY, 32'h2);
    wr(`BERS_A_ENG, 32'h3);
    wr(`BERS_A_RSTW, 32'h3);
    wr(`BERS_A_REL, 32'h1);
    wr(`BERS_A_FBF, 32'h0006_0000);
    wr(`BERS_A_JDC, 32'h0046_0019);
    wr(`BERS_A_CTRL, 32'h0);
    // Full sequence, policy zero
    run_req <= 1'b1;
    wait_st(3'd1, n);
    wait_st(3'd2, n);
    chk("run_en", 32'h1, 32'(run_en));
    foreach (jrows[i]) begin
      wr(`BERS_A_CTRL, 32'(jrows[i].ctrl));
      rev_req <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk("jump_act", 32'(jrows[i].act), 32'(jmp_act));
      if (jrows[i].act) chk("jump_f", 32'(jrows[i].freq), 32'(jmp_f));
      rev_req <= 1'b0;
      @(posedge mclk_i);
    end
    wr(`BERS_A_CTRL, 32'h0);
    run_req  <= 1'b0;
    stop_req <= 1'b1;
    wait_st(3'd3, n);
    chk("brake_dly", 32'h0, 32'(brake));
    chk("dc_en", 32'h1, 32'(dc_en));
    chk("dc_lvl", 32'h46, 32'(dc_lvl));
    wait_st(3'd4, n);
    chk_rng("dly_len", 2, 12, n);
    chk("brake_ph", 32'h1, 32'(brake));
    run_req <= 1'b1;
    wait_st(3'd5, n);
    chk_rng("ph_len", 16, 28, n);
    stop_req <= 1'b0;
    wait_st(3'd1, n);
    wait_st(3'd2, n);
    // Policy one: run before the delay ends skips the engage
    wr(`BERS_A_CTRL, 32'h2);
    wr(`BERS_A_DLY, 32'h14);
    rd(`BERS_A_STAT, d);
    chk("eff_pol1", 32'h1, 32'(d[4]));
    run_req  <= 1'b0;
    stop_req <= 1'b1;
    wait_st(3'd3, n);
    run_req  <= 1'b1;
    stop_req <= 1'b0;
    wait_st(3'd2, n);
    chk_rng("run_back", 0, 8, n);
    chk("brake_skip", 32'h0, 32'(brake));
    // Policy one: run during engage phase goes through release time
    run_req  <= 1'b0;
    stop_req <= 1'b1;
    wait_st(3'd4, n);
    run_req  <= 1'b1;
    stop_req <= 1'b0;
    wait_st(3'd0 + 3'd1, n);
    chk_rng("rel_fast", 0, 6, n);
    wait_st(3'd2, n);
    // Run during restart wait starts the wait again
    run_req  <= 1'b0;
    stop_req <= 1'b1;
    wait_st(3'd5, n);
    stop_req <= 1'b0;
    run_req  <= 1'b1;
    repeat (2) @(posedge mclk_i);
    run_req <= 1'b0;
    wait_st(3'd0, n);
    chk_rng("wait_again", 12, 16, n);
    wr(`BERS_A_CTRL, 32'h22);
    rd(`BERS_A_STAT, d);
    chk("eff_pol_ms", 32'h0, 32'(d[4]));
    // Reversal engage: run in delay is not honoured
    wr(`BERS_A_CTRL, 32'h3);
    run_req <= 1'b1;
    wait_st(3'd2, n);
    run_req <= 1'b0;
    rev_req <= 1'b1;
    wait_st(3'd3, n);
    rd(`BERS_A_STAT, d);
    chk("rev_act", 32'h1, 32'(d[5]));
    rev_req <= 1'b0;
    run_req <= 1'b1;
    wait_st(3'd4, n);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
